// ---- hdl/lsg_pkg.sv ----
`default_nettype none
package lsg_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int PORT_COUNT = 4;
  localparam int PORT_W     = 8;
  localparam int PIN_W      = 32;
  localparam int ADDR_W     = 16;
  localparam int DATA_W     = 32;
  localparam int IDX_W      = 12;

  // ****************************************
  // Register indices, byte address is four times
  // ****************************************
  localparam logic [3:0][11:0] IDX_LATCH = {12'h008, 12'h007, 12'h006, 12'h005};
  localparam logic [3:0][11:0] IDX_SEG   = {12'h fd8, 12'hfd7, 12'hfd6, 12'hfd5};
  localparam logic [3:0][11:0] IDX_PIN   = {12'hff8, 12'hff7, 12'hff6, 12'hff5};
  localparam logic [3:0][11:0] IDX_DRIVE = {12'hfff, 12'hffe, 12'hffd, 12'hffc};

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] LATCH_RST = 8'hff;
  localparam logic [7:0] DRIVE_RST = 8'h00;
  localparam logic [7:0] SEG_RST   = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    LSG_K_LATCH = 2'b00,
    LSG_K_SEG   = 2'b01,
    LSG_K_PIN   = 2'b10,
    LSG_K_DRIVE = 2'b11
  } lsg_kind_e;

  typedef struct packed {
    logic      hit;
    logic [1:0] port;
    lsg_kind_e kind;
  } lsg_dec_s;

  typedef struct packed {
    logic [7:0] latch;
    logic [7:0] drive;
    logic [7:0] seg;
  } lsg_cfg_s;

  // ****************************************
  // Functions
  // ****************************************
  function automatic lsg_dec_s lsg_decode(input logic [15:0] addr);
    lsg_dec_s d;
    logic [11:0] idx;
    d   = '{hit: 1'b0, port: 2'b00, kind: LSG_K_LATCH};
    idx = addr[13:2];
    if (addr[1:0] == 2'b00 && addr[15:14] == 2'b00) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        if (idx == IDX_LATCH[p]) d = '{hit: 1'b1, port: 2'(p), kind: LSG_K_LATCH};
        if (idx == IDX_SEG[p])   d = '{hit: 1'b1, port: 2'(p), kind: LSG_K_SEG};
        if (idx == IDX_PIN[p])   d = '{hit: 1'b1, port: 2'(p), kind: LSG_K_PIN};
        if (idx == IDX_DRIVE[p]) d = '{hit: 1'b1, port: 2'(p), kind: LSG_K_DRIVE};
      end
    end
    return d;
  endfunction

  function automatic logic [7:0] lsg_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++) r[i] = v[7 - i];
    return r;
  endfunction
endpackage
`default_nettype wire

// ---- hdl/lsg_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsg_sync #(
  parameter int W = 32
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  // ****************************************
  // Two-flop pin synchroniser
  // ****************************************
  always_comb begin
    s1_nxt = ce ? d : s1_r;
    s2_nxt = ce ? s1_r : s2_r;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Reset high like idle pins, so no false edge reaches peripherals
      s1_r <= '1;
      s2_r <= '1;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q = s2_r;
endmodule
`default_nettype wire

// ---- hdl/lsg_port_drive.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsg_port_drive (
  input  wire lsg_pkg::lsg_cfg_s cfg,
  input  wire logic [7:0]        seg,
  input  wire logic [7:0]        alt,
  output logic      [7:0]        out_nxt,
  output logic      [7:0]        oe_nxt
);
  logic [7:0] level;

  // ****************************************
  // Per-pin output stage
  // ****************************************
  always_comb begin
    // Peripheral idles high, so latch one passes it through
    level   = cfg.latch & alt;
    out_nxt = (cfg.seg & seg) | (~cfg.seg & level);
    oe_nxt  = cfg.seg | ~level | cfg.drive;
  end
endmodule
`default_nettype wire

// ---- hdl/lsg_gpio_top.sv ----
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module lsg_gpio_top (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] pin_in,
  output logic      [31:0] pin_out,
  output logic      [31:0] pin_oe,
  input  wire logic [31:0] lcd_seg,
  input  wire logic [7:0]  alt_out_a,
  output logic      [7:0]  alt_in_a
);
  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rsync_r;
  logic       rst_sync_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rsync_r <= 2'b00;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end

  assign rst_sync_n = rsync_r[1];

  // ****************************************
  // Pin input synchroniser
  // ****************************************
  logic [31:0] pin_sync;

  lsg_sync #(
    .W (lsg_pkg::PIN_W)
  ) u_sync (
    .clock (clock),
    .rst_n (rst_sync_n),
    .ce    (ce),
    .d     (pin_in),
    .q     (pin_sync)
  );

  assign alt_in_a = pin_sync[7:0];

  // ****************************************
  // Address decode
  // ****************************************
  lsg_pkg::lsg_dec_s dec;
  logic              access;
  logic              wr_fire;

  assign dec     = lsg_pkg::lsg_decode(paddr);
  assign access  = psel & penable;
  assign wr_fire = access & pready & pwrite;

  // ****************************************
  // Port configuration
  // ****************************************
  lsg_pkg::lsg_cfg_s [3:0] cfg_r;
  lsg_pkg::lsg_cfg_s [3:0] cfg_nxt;

  always_comb begin
    cfg_nxt = cfg_r;
    // Write lands on the completing edge only
    if (wr_fire && dec.hit) begin
      case (dec.kind)
        lsg_pkg::LSG_K_LATCH: begin
          cfg_nxt[dec.port].latch = pwdata[7:0];
        end
        lsg_pkg::LSG_K_SEG: begin
          cfg_nxt[dec.port].seg = pwdata[7:0];
        end
        lsg_pkg::LSG_K_DRIVE: begin
          cfg_nxt[dec.port].drive = pwdata[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      for (int p = 0; p < lsg_pkg::PORT_COUNT; p++) begin
        cfg_r[p] <= '{latch: lsg_pkg::LATCH_RST, drive: lsg_pkg::DRIVE_RST, seg: lsg_pkg::SEG_RST};
      end
    end else if (ce) begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************
  // APB slave, one wait state
  // ****************************************
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [31:0] prdata_nxt;
  logic [7:0]  rd_byte;

  always_comb begin
    case (dec.kind)
      lsg_pkg::LSG_K_LATCH: rd_byte = cfg_r[dec.port].latch;
      lsg_pkg::LSG_K_SEG:   rd_byte = cfg_r[dec.port].seg;
      lsg_pkg::LSG_K_PIN:   rd_byte = pin_sync[dec.port*8 +: 8];
      lsg_pkg::LSG_K_DRIVE: rd_byte = cfg_r[dec.port].drive;
      default:              rd_byte = 8'h00;
    endcase
    pready_nxt  = access & ~pready;
    pslverr_nxt = access & ~pready & ~dec.hit;
    prdata_nxt  = (pready_nxt && !pwrite && dec.hit) ? {24'h000000, rd_byte} : 32'h00000000;
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
      prdata  <= prdata_nxt;
    end
  end

  // ****************************************
  // Output stages
  // ****************************************
  logic [31:0] seg_src;
  logic [31:0] alt_src;
  logic [31:0] out_nxt;
  logic [31:0] oe_nxt;

  assign seg_src = {lsg_pkg::lsg_rev8(lcd_seg[31:24]), lcd_seg[23:0]};
  assign alt_src = {24'hffffff, alt_out_a};

  for (genvar g = 0; g < lsg_pkg::PORT_COUNT; g++) begin : g_port
    lsg_port_drive u_drive (
      .cfg     (cfg_r[g]),
      .seg     (seg_src[g*8 +: 8]),
      .alt     (alt_src[g*8 +: 8]),
      .out_nxt (out_nxt[g*8 +: 8]),
      .oe_nxt  (oe_nxt[g*8 +: 8])
    );
  end

  // Registered so pins never glitch on decode
  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_out <= 32'h00000000;
      pin_oe  <= 32'h00000000;
    end else if (ce) begin
      pin_out <= out_nxt;
      pin_oe  <= oe_nxt;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [31:0] latch_all;
  logic [31:0] drive_all;
  logic [31:0] seg_all;

  always_comb begin
    for (int p = 0; p < lsg_pkg::PORT_COUNT; p++) begin
      latch_all[p*8 +: 8] = cfg_r[p].latch;
      drive_all[p*8 +: 8] = cfg_r[p].drive;
      seg_all[p*8 +: 8]   = cfg_r[p].seg;
    end
  end

  property p_reset_values;
    @(posedge clock) disable iff (!reset_n)
    $rose(rst_sync_n) |-> latch_all == 32'hffffffff && drive_all == 32'h00000000 && seg_all == 32'h00000000;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Reset values wrong");

  property p_seg_drive;
    @(posedge clock) disable iff (!rst_sync_n)
    ce |=> ((pin_oe & $past(seg_all)) == $past(seg_all))
           && (((pin_out ^ $past(seg_src)) & $past(seg_all)) == 32'h00000000);
  endproperty
  a_seg_drive: assert property (p_seg_drive) else $error("Segment pin not driven");

  property p_drive_mode;
    @(posedge clock) disable iff (!rst_sync_n)
    ce |=> ((~$past(seg_all) & $past(latch_all & alt_src) & ~$past(drive_all) & pin_oe) == 32'h00000000)
           && ((~$past(seg_all) & $past(latch_all & alt_src) & $past(drive_all) & ~(pin_oe & pin_out))
               == 32'h00000000);
  endproperty
  a_drive_mode: assert property (p_drive_mode) else $error("Drive mode wrong");

  property p_latch_low;
    @(posedge clock) disable iff (!rst_sync_n)
    ce |=> ((~$past(seg_all) & ~$past(latch_all & alt_src) & ~(pin_oe & ~pin_out)) == 32'h00000000);
  endproperty
  a_latch_low: assert property (p_latch_low) else $error("Latch zero not driven low");

  property p_read_latch;
    @(posedge clock) disable iff (!rst_sync_n)
    (access && pready && !pwrite && dec.hit && dec.kind == lsg_pkg::LSG_K_LATCH)
      |-> prdata[7:0] == cfg_r[dec.port].latch;
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("Latch read wrong");

  property p_read_pins;
    @(posedge clock) disable iff (!rst_sync_n)
    (access && pready && !pwrite && dec.hit && dec.kind == lsg_pkg::LSG_K_PIN)
      |-> prdata[7:0] == $past(pin_sync[dec.port*8 +: 8]);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("Pin read wrong");

  property p_byte_wide;
    @(posedge clock) disable iff (!rst_sync_n)
    pready |-> prdata[31:8] == 24'h000000 && $past(access) && !$past(pready);
  endproperty
  a_byte_wide: assert property (p_byte_wide) else $error("Upper bits or timing wrong");

  property p_reversed;
    @(posedge clock) disable iff (!rst_sync_n)
    ce |=> ((pin_out[31:24] ^ lsg_pkg::lsg_rev8($past(lcd_seg[31:24]))) & $past(cfg_r[3].seg)) == 8'h00;
  endproperty
  a_reversed: assert property (p_reversed) else $error("Last port order wrong");

  property p_sync_delay;
    @(posedge clock) disable iff (!rst_sync_n)
    (ce && $past(ce) && $past(rst_sync_n)) |=> pin_sync == $past(pin_in, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("Pin sync delay wrong");

  property p_reset_outputs;
    @(posedge clock) disable iff (!reset_n)
    $rose(rst_sync_n) |-> pin_out == 32'h00000000 && pin_oe == 32'h00000000
                          && !pready && !pslverr && prdata == 32'h00000000;
  endproperty
  a_reset_outputs: assert property (p_reset_outputs) else $error("Outputs not quiet in reset");

  // Release waits two edges so all flops on rst_sync_n leave reset together
  property p_reset_release;
    @(posedge clock) disable iff (!reset_n)
    $rose(rst_sync_n) |-> $past(reset_n, 2);
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("Reset released too early");

  // Clock enable low holds every register but the reset synchroniser, handshake too
  property p_ce_freeze;
    @(posedge clock) disable iff (!rst_sync_n)
    !ce |=> cfg_r == $past(cfg_r) && pin_out == $past(pin_out) && pin_oe == $past(pin_oe)
            && pready == $past(pready) && pin_sync == $past(pin_sync);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("State moved with clock enable low");

  property p_write_lands;
    @(posedge clock) disable iff (!rst_sync_n)
    (ce && wr_fire && dec.hit && dec.kind == lsg_pkg::LSG_K_LATCH)
      |=> cfg_r[$past(dec.port)].latch == $past(pwdata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("Latch write lost");

  property p_pin_write_ignored;
    @(posedge clock) disable iff (!rst_sync_n)
    (wr_fire && dec.kind == lsg_pkg::LSG_K_PIN) |=> cfg_r == $past(cfg_r);
  endproperty
  a_pin_write_ignored: assert property (p_pin_write_ignored) else $error("Pin-state write changed config");

  // Unmapped or unaligned: error, empty data, write dropped
  property p_bad_addr;
    @(posedge clock) disable iff (!rst_sync_n)
    (ce && access && !pready && !dec.hit)
      |=> (pready && pslverr && prdata == 32'h00000000) ##1 cfg_r == $past(cfg_r);
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("Bad address not refused");

  property p_idle_outputs;
    @(posedge clock) disable iff (!rst_sync_n)
    !pready |-> prdata == 32'h00000000 && !pslverr;
  endproperty
  a_idle_outputs: assert property (p_idle_outputs) else $error("Read data outside completion");

  c_seg_write: cover property (@(posedge clock) disable iff (!rst_sync_n)
    wr_fire && dec.hit && dec.kind == lsg_pkg::LSG_K_SEG);
  c_pin_read: cover property (@(posedge clock) disable iff (!rst_sync_n)
    access && pready && !pwrite && dec.kind == lsg_pkg::LSG_K_PIN);
  c_bad_addr: cover property (@(posedge clock) disable iff (!rst_sync_n) pslverr);
  c_open_drain: cover property (@(posedge clock) disable iff (!rst_sync_n) ce && pin_oe != 32'hffffffff);
  c_clock_hold: cover property (@(posedge clock) disable iff (!rst_sync_n) !ce);
endmodule
`default_nettype wire

// ---- dv/lsg_pin_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lsg_pin_model (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic        ext_en,
  input  wire logic [7:0]  ext_val,
  output logic      [31:0] pin_in
);
  // ****************************************
  // Pin resolution
  // ****************************************
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pin_oe[i] === 1'b1) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en && i >= 8 && i < 16) begin
        pin_in[i] = ext_val[i - 8];
      end else begin
        pin_in[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/lcd_shared_gpio_ports_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module lcd_shared_gpio_ports_test;
  logic        clock;
  logic        reset_n;
  logic        ce;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] pin_in;
  logic [31:0] pin_out;
  logic [31:0] pin_oe;
  logic [31:0] lcd_seg;
  logic [7:0]  alt_out_a;
  logic [7:0]  alt_in_a;
  logic        ext_en;
  logic [7:0]  ext_val;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          n_compared;

  lsg_gpio_top lsg_gpio_top_i (
    .clock(clock), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .lcd_seg(lcd_seg), .alt_out_a(alt_out_a), .alt_in_a(alt_in_a)
  );

  lsg_pin_model lsg_pin_model_i (
    .pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("Error at %0t: no ready", $time);
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    apb(1'b1, {2'b00, i, 2'b00}, {24'h0, d});
  endtask

  task automatic rchk(input logic [11:0] i, input logic [7:0] x);
    apb(1'b0, {2'b00, i, 2'b00}, 32'h0);
    chk(rd, {24'h0, x});
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    reset_n   = 1'b0;
    ce        = 1'b1;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 16'h0000;
    pwdata    = 32'h0;
    lcd_seg   = 32'h0;
    alt_out_a = 8'hff;
    ext_en    = 1'b0;
    ext_val   = 8'h00;
    bad_count  = 0;
    n_compared = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk(pin_oe, 32'h0);
    chk(pin_out, 32'hffffffff);
    for (int p = 0; p < 4; p++) begin
      rchk(lsg_pkg::IDX_LATCH[p], 8'hff);
      rchk(lsg_pkg::IDX_DRIVE[p], 8'h00);
      rchk(lsg_pkg::IDX_SEG[p], 8'h00);
    end
    wr(lsg_pkg::IDX_LATCH[1], 8'h0f);
    wr(lsg_pkg::IDX_DRIVE[1], 8'h3c);
    repeat (4) @(posedge clock);
    chk(pin_oe, 32'h0000fc00);
    chk(pin_out, 32'hffff0fff);
    rchk(lsg_pkg::IDX_LATCH[1], 8'h0f);
    rchk(lsg_pkg::IDX_PIN[1], 8'h0f);
    wr(lsg_pkg::IDX_LATCH[1], 8'hff);
    wr(lsg_pkg::IDX_DRIVE[1], 8'h00);
    ext_en  <= 1'b1;
    ext_val <= 8'ha5;
    repeat (4) @(posedge clock);
    chk(pin_oe, 32'h0);
    rchk(lsg_pkg::IDX_PIN[1], 8'ha5);
    rchk(lsg_pkg::IDX_LATCH[1], 8'hff);
    wr(lsg_pkg::IDX_PIN[1], 8'h00);
    chk({31'h0, er}, 32'h0);
    rchk(lsg_pkg::IDX_PIN[1], 8'ha5);
    lcd_seg <= 32'h01000000;
    wr(lsg_pkg::IDX_LATCH[3], 8'h00);
    wr(lsg_pkg::IDX_SEG[3], 8'h81);
    rchk(lsg_pkg::IDX_SEG[3], 8'h81);
    repeat (4) @(posedge clock);
    chk(pin_oe, 32'hff000000);
    chk(pin_out, 32'h80ffffff);
    wr(lsg_pkg::IDX_LATCH[0], 8'hff);
    wr(lsg_pkg::IDX_SEG[0], 8'h00);
    wr(lsg_pkg::IDX_DRIVE[0], 8'hff);
    alt_out_a <= 8'h5a;
    repeat (5) @(posedge clock);
    chk(pin_oe, 32'hff0000ff);
    chk(pin_out, 32'h80ffff5a);
    chk({24'h0, alt_in_a}, 32'h5a);
    rchk(lsg_pkg::IDX_DRIVE[0], 8'hff);
    ce        <= 1'b0;
    alt_out_a <= 8'ha5;
    repeat (4) @(posedge clock);
    chk(pin_out, 32'h80ffff5a);
    ce <= 1'b1;
    repeat (3) @(posedge clock);
    chk(pin_out, 32'h80ffffa5);
    apb(1'b0, 16'h0000, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 16'h0015, 32'h0);
    chk({31'h0, er}, 32'h1);
    reset_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk(pin_oe, 32'h0);
    chk(pin_out, 32'h0);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    rchk(lsg_pkg::IDX_SEG[3], 8'h00);
    rchk(lsg_pkg::IDX_DRIVE[0], 8'h00);
    rchk(lsg_pkg::IDX_LATCH[0], 8'hff);
    wrap_up();
  end
endmodule
`default_nettype wire
